// [src/sfe_consts.svh]
// Purpose: offsets, reset values, field positions and timing for sfe
// Assumes: 32-bit APB, byte addresses, one register per word
// Notes: reset values are the stored defaults restored at power return
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH
`define SFE_OFF_SEL 8'h00
`define SFE_OFF_FIXED 8'h04
`define SFE_OFF_CAP 8'h08
`define SFE_OFF_LFPOS 8'h0C
`define SFE_OFF_LFW 8'h10
`define SFE_OFF_TRAIL 8'h14
`define SFE_OFF_REPLY 8'h18
`define SFE_OFF_WHOLE 8'h1C
`define SFE_OFF_GAP 8'h20
`define SFE_OFF_DMASK 8'h24
`define SFE_OFF_DPAT_LO 8'h28
`define SFE_OFF_DPAT_HI 8'h2C
`define SFE_OFF_BAUD 8'h30
`define SFE_OFF_STATUS 8'h34
`define SFE_RST_SEL 7'h00
`define SFE_RST_FIXED 16'h0001
`define SFE_RST_CAP 16'h0001
`define SFE_RST_LFPOS 16'h0000
`define SFE_RST_LFW 3'h0
`define SFE_RST_TRAIL 8'h00
`define SFE_RST_REPLY 16'h00C8
`define SFE_RST_WHOLE 16'h00C8
`define SFE_RST_GAP 16'h000C
`define SFE_RST_DMASK 5'h00
`define SFE_RST_DPAT 40'h00_0000_0000
`define SFE_RST_BAUD 16'h0364
`define SFE_EC_REPLY 0
`define SFE_EC_WHOLE 1
`define SFE_EC_GAP 2
`define SFE_EC_CAP 3
`define SFE_EC_LFIELD 4
`define SFE_EC_DELIM 5
`define SFE_EC_FIXED 6
`define SFE_PCLK_NS 10
`define SFE_MS_NS 1000000
`endif

// [src/sfe_pkg.sv]
// Purpose: shared types for the frame end detector
// Assumes: nothing
// Notes: constants live in sfe_consts.svh
package sfe_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_REPLY, ST_FRAME} sfe_state_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sfe_rx_t;
endpackage : sfe_pkg

// [src/sfe_tick.sv]
// Purpose: divider giving a one-cycle tick every div cycles
// Assumes: div of 0 or 1 ticks every cycle
// Notes: clear restarts the phase
`timescale 1ns/10ps
`default_nettype none
module sfe_tick #(
   parameter int W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic clear,
   input wire logic [W-1:0] div,
   output logic tick
);
   logic [W-1:0] cnt;
   wire last = (div <= W'(1)) || (cnt >= div - W'(1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         cnt <= (clear || last) ? '0 : cnt + W'(1);
         tick <= !clear && last;
      end
   end
endmodule : sfe_tick
`default_nettype wire

// [src/sfe_delim.sv]
// Purpose: five-character history compared with a masked pattern
// Assumes: position 5 holds the newest character
// Notes: a masked-off position matches anything
`timescale 1ns/10ps
`default_nettype none
module sfe_delim (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic clear,
   input wire logic push,
   input wire logic [7:0] data,
   input wire logic [4:0] mask,
   input wire logic [39:0] pat,
   output logic match
);
   logic [39:0] hist;
   logic [4:0] pos_ok;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist <= '0;
      end else if (ce) begin
         if (clear || push) begin
            hist <= {push ? data : 8'h00, clear ? 32'h0000_0000 : hist[39:8]};
         end
      end
   end
   for (genvar i = 0; i < 5; i++) begin : g_pos
      assign pos_ok[i] = !mask[i] || (hist[8*i +: 8] == pat[8*i +: 8]);
   end
   assign match = (|mask) && (&pos_ok);
endmodule : sfe_delim
`default_nettype wire

// [src/sfe_frame_end.sv]
// Purpose: receive-side frame end detector with APB configuration
// Assumes: rx characters and frame_start come from logic on pclk
// Notes: closes at most one frame per cycle
// What this block does
// - Frame ends as soon as any enabled end condition is true.
// - Select bits 01H reply timeout, 02H frame timeout, 04H gap.
// - Select bits 08H cap, 10H length field, 20H delimiter, 40H fixed.
// - Fixed framing ends after the configured byte count, default 1.
// - Cap framing ends when byte count reaches the maximum.
// - Length field sits at configurable byte position N.
// - Length field is 1, 2 or 4 bytes wide.
// - M trailing characters follow, excluded from the length value.
// - After transmit, wait reply_wait_ms for a first char, else error.
// - Whole-frame timer starts at first character, ends frame on expiry.
// - Frame ends when idle gap exceeds the bit-time limit.
// - Delimiter mask bit 0 is char 1 up to bit 4 char 5.
// - Five-character pattern compared with the newest characters.
// - Reset restores stored defaults; writes override them later.
// - End conditions other than the reply timeout are only evaluated once the frame has started.
`include "sfe_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sfe_frame_end #(
   parameter int MS_CYCLES = `SFE_MS_NS / `SFE_PCLK_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sfe_pkg::sfe_rx_t rx,
   input wire logic frame_start,
   input wire logic tx_done,
   output logic frame_end,
   output logic [6:0] end_cause,
   output logic reply_err,
   output logic in_frame
);
   import sfe_pkg::*;

   logic [6:0] end_condition_select;
   logic [15:0] fixed_frame_bytes;
   logic [15:0] frame_length_cap;
   logic [15:0] lfield_pos;
   logic [2:0] length_field_width;
   logic [7:0] trailing_uncounted_chars;
   logic [15:0] reply_wait_ms;
   logic [15:0] whole_frame_wait_ms;
   logic [15:0] inter_char_gap_limit;
   logic [4:0] delimiter_enable_mask;
   logic [39:0] delimiter_pattern;
   logic [15:0] baud_div;

   sfe_state_t st;
   sfe_state_t next_st;
   logic [15:0] cnt;
   logic [15:0] ms_cnt;
   logic [15:0] gap_cnt;
   logic [31:0] lf_val;
   logic [31:0] lf_target;
   logic lf_done;
   logic [31:0] rd_data;
   logic rd_hit;

   // apb decode
   wire setup = psel && !penable;
   wire wr = psel && penable && pready && pwrite;

   // frame control
   wire in_fr = (st == ST_FRAME);
   wire opening = frame_start && !in_fr;
   wire got_first = (cnt != 16'h0000);
   wire [31:0] npos = opening ? 32'h0000_0001 : 32'(cnt) + 32'h0000_0001;
   wire [31:0] lf_w = (length_field_width == 3'h4) ? 32'h0000_0004 :
                      (length_field_width == 3'h2) ? 32'h0000_0002 :
                      32'h0000_0001;
   wire [31:0] lf_last = 32'(lfield_pos) + lf_w - 32'h0000_0001;
   wire [31:0] lf_base = opening ? 32'h0000_0000 : lf_val;
   wire [31:0] lf_shift = {lf_base[23:0], rx.data};
   wire ms_tick;
   wire bit_tick;
   wire dmatch;
   wire [6:0] hits;
   wire [6:0] fired = hits & end_condition_select;
   wire close = |fired;
   wire acc = rx.valid && !close && (in_fr || frame_start);
   wire first_char = acc && (opening || !got_first);
   assign hits[`SFE_EC_REPLY] = (st == ST_REPLY) &&
      (ms_cnt >= reply_wait_ms);
   assign hits[`SFE_EC_WHOLE] = in_fr && got_first &&
      (ms_cnt >= whole_frame_wait_ms);
   assign hits[`SFE_EC_GAP] = in_fr && got_first &&
      (gap_cnt > inter_char_gap_limit);
   assign hits[`SFE_EC_CAP] = in_fr && (cnt >= frame_length_cap);
   assign hits[`SFE_EC_LFIELD] = in_fr && lf_done &&
      (32'(cnt) >= lf_target);
   assign hits[`SFE_EC_DELIM] = in_fr && got_first && dmatch;
   assign hits[`SFE_EC_FIXED] = in_fr && (cnt >= fixed_frame_bytes);
   always_comb begin
      next_st = st;
      unique case (st)
         ST_IDLE: begin
            if (frame_start) begin
               next_st = ST_FRAME;
            end else if (tx_done && end_condition_select[`SFE_EC_REPLY]) begin
               next_st = ST_REPLY;
            end
         end
         ST_REPLY: begin
            if (close) begin
               next_st = ST_IDLE;
            end else if (frame_start) begin
               next_st = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (close) begin
               next_st = ST_IDLE;
            end
         end
      endcase
   end

   // ticks for gap and timeout counters
   sfe_tick #(.W(16)) u_bit_tick (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clear(acc),
      .div(baud_div),
      .tick(bit_tick)
   );
   sfe_tick #(.W(32)) u_ms_tick (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clear(tx_done || first_char),
      .div(32'(MS_CYCLES)),
      .tick(ms_tick)
   );
   sfe_delim u_delim (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .clear(opening),
      .push(acc),
      .data(rx.data),
      .mask(delimiter_enable_mask),
      .pat(delimiter_pattern),
      .match(dmatch)
   );
   // register writes, reset values are the stored defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         end_condition_select <= `SFE_RST_SEL;
         fixed_frame_bytes <= `SFE_RST_FIXED;
         frame_length_cap <= `SFE_RST_CAP;
         lfield_pos <= `SFE_RST_LFPOS;
         length_field_width <= `SFE_RST_LFW;
         trailing_uncounted_chars <= `SFE_RST_TRAIL;
         reply_wait_ms <= `SFE_RST_REPLY;
         whole_frame_wait_ms <= `SFE_RST_WHOLE;
         inter_char_gap_limit <= `SFE_RST_GAP;
         delimiter_enable_mask <= `SFE_RST_DMASK;
         delimiter_pattern <= `SFE_RST_DPAT;
         baud_div <= `SFE_RST_BAUD;
      end else if (ce && wr) begin
         case (paddr)
            `SFE_OFF_SEL: end_condition_select <= pwdata[6:0];
            `SFE_OFF_FIXED: fixed_frame_bytes <= pwdata[15:0];
            `SFE_OFF_CAP: frame_length_cap <= pwdata[15:0];
            `SFE_OFF_LFPOS: lfield_pos <= pwdata[15:0];
            `SFE_OFF_LFW: length_field_width <= pwdata[2:0];
            `SFE_OFF_TRAIL: trailing_uncounted_chars <= pwdata[7:0];
            `SFE_OFF_REPLY: reply_wait_ms <= pwdata[15:0];
            `SFE_OFF_WHOLE: whole_frame_wait_ms <= pwdata[15:0];
            `SFE_OFF_GAP: inter_char_gap_limit <= pwdata[15:0];
            `SFE_OFF_DMASK: delimiter_enable_mask <= pwdata[4:0];
            `SFE_OFF_DPAT_LO: delimiter_pattern[31:0] <= pwdata;
            `SFE_OFF_DPAT_HI: delimiter_pattern[39:32] <= pwdata[7:0];
            `SFE_OFF_BAUD: baud_div <= pwdata[15:0];
            default: ;
         endcase
      end
   end
   // read selection
   always_comb begin
      rd_hit = 1'b1;
      unique case (paddr)
         `SFE_OFF_SEL: rd_data = {25'h0, end_condition_select};
         `SFE_OFF_FIXED: rd_data = {16'h0, fixed_frame_bytes};
         `SFE_OFF_CAP: rd_data = {16'h0, frame_length_cap};
         `SFE_OFF_LFPOS: rd_data = {16'h0, lfield_pos};
         `SFE_OFF_LFW: rd_data = {29'h0, length_field_width};
         `SFE_OFF_TRAIL: rd_data = {24'h0, trailing_uncounted_chars};
         `SFE_OFF_REPLY: rd_data = {16'h0, reply_wait_ms};
         `SFE_OFF_WHOLE: rd_data = {16'h0, whole_frame_wait_ms};
         `SFE_OFF_GAP: rd_data = {16'h0, inter_char_gap_limit};
         `SFE_OFF_DMASK: rd_data = {27'h0, delimiter_enable_mask};
         `SFE_OFF_DPAT_LO: rd_data = delimiter_pattern[31:0];
         `SFE_OFF_DPAT_HI: rd_data = {24'h0, delimiter_pattern[39:32]};
         `SFE_OFF_BAUD: rd_data = {16'h0, baud_div};
         `SFE_OFF_STATUS: rd_data = {cnt, 1'b0, end_cause, 6'h0,
                                     (st == ST_REPLY), in_fr};
         default: begin
            rd_data = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end
   // apb answer: one wait-free access phase after each setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= setup;
         pslverr <= setup && !rd_hit;
         if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
         end
      end
   end
   // frame state and counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= ST_IDLE;
         cnt <= 16'h0000;
         ms_cnt <= 16'h0000;
         gap_cnt <= 16'h0000;
      end else if (ce) begin
         st <= next_st;
         if (opening) begin
            cnt <= acc ? 16'h0001 : 16'h0000;
         end else if (acc && cnt != 16'hFFFF) begin
            cnt <= cnt + 16'h0001;
         end
         if (tx_done || first_char) begin
            ms_cnt <= 16'h0000;
         end else if (ms_tick && ms_cnt != 16'hFFFF) begin
            ms_cnt <= ms_cnt + 16'h0001;
         end
         if (acc) begin
            gap_cnt <= 16'h0000;
         end else if (bit_tick && gap_cnt != 16'hFFFF) begin
            gap_cnt <= gap_cnt + 16'h0001;
         end
      end
   end
   // length field capture, big-endian
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_val <= 32'h0000_0000;
         lf_target <= 32'h0000_0000;
         lf_done <= 1'b0;
      end else if (ce) begin
         if (opening) begin
            lf_val <= 32'h0000_0000;
            lf_done <= 1'b0;
         end
         if (acc && npos >= 32'(lfield_pos) && npos <= lf_last &&
             (opening || !lf_done)) begin
            lf_val <= lf_shift;
            if (npos == lf_last) begin
               lf_done <= 1'b1;
               lf_target <= npos + lf_shift +
                  32'(trailing_uncounted_chars);
            end
         end
      end
   end
   // outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_end <= 1'b0;
         end_cause <= 7'h00;
         reply_err <= 1'b0;
         in_frame <= 1'b0;
      end else if (ce) begin
         frame_end <= close;
         if (close) begin
            end_cause <= fired;
         end
         reply_err <= fired[`SFE_EC_REPLY];
         in_frame <= (next_st == ST_FRAME);
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_open_with_char;
      ce && opening && acc;
   endsequence
   AST_CLOSE_ONCE: assert property (ce && close |=> frame_end &&
      end_cause == $past(fired) && !in_frame)
      else $error("close did not give one frame end with causes");
   AST_NO_EVAL_IDLE: assert property (ce && st == ST_IDLE |-> !close)
      else $error("end condition evaluated outside a frame");
   AST_FIRST_BYTE: assert property (s_open_with_char |=> cnt == 16'h0001)
      else $error("first byte of a frame not counted");
   AST_FIXED: assert property (ce && in_fr &&
      end_condition_select[`SFE_EC_FIXED] && cnt >= fixed_frame_bytes
      |=> frame_end && end_cause[`SFE_EC_FIXED])
      else $error("fixed length did not close the frame");
   AST_CAP: assert property (ce && in_fr &&
      end_condition_select[`SFE_EC_CAP] && cnt >= frame_length_cap
      |=> frame_end && end_cause[`SFE_EC_CAP])
      else $error("length cap did not close the frame");
   AST_GAP: assert property (ce && in_fr && got_first &&
      end_condition_select[`SFE_EC_GAP] && gap_cnt > inter_char_gap_limit
      |=> frame_end && end_cause[`SFE_EC_GAP])
      else $error("gap limit did not close the frame");
   AST_REPLY: assert property (ce && st == ST_REPLY &&
      end_condition_select[`SFE_EC_REPLY] && ms_cnt >= reply_wait_ms
      |=> reply_err && frame_end && !in_frame)
      else $error("reply timeout did not end with error");
   AST_WHOLE: assert property (ce && in_fr && got_first &&
      end_condition_select[`SFE_EC_WHOLE] && ms_cnt >= whole_frame_wait_ms
      |=> end_cause[`SFE_EC_WHOLE])
      else $error("frame timeout did not close the frame");
   AST_DELIM: assert property (ce && in_fr && got_first && dmatch &&
      end_condition_select[`SFE_EC_DELIM] |=> end_cause[`SFE_EC_DELIM])
      else $error("delimiter match did not close the frame");
   AST_SEL_ONLY: assert property (ce && in_fr &&
      end_condition_select == 7'h00 |=> !frame_end)
      else $error("frame closed with no condition selected");
endmodule : sfe_frame_end
`default_nettype wire

// [test/sfe_remote.sv]
// Purpose: remote serial partner sending framed characters
// Assumes: at most one character per pclk cycle
// Notes: idle data shows the inverse of the last character
`timescale 1ns/10ps
`default_nettype none
module sfe_remote (
   input wire logic pclk,
   output sfe_pkg::sfe_rx_t rx,
   output logic frame_start,
   output logic tx_done
);
   import sfe_pkg::*;
   initial begin
      rx = '0;
      frame_start = 1'b0;
      tx_done = 1'b0;
   end
   // one frame, the first character opens it
   task automatic send(input logic [7:0] q[$], input int space);
      for (int i = 0; i < q.size(); i++) begin
         @(posedge pclk);
         rx <= '{valid: 1'b1, data: q[i]};
         frame_start <= (i == 0);
         for (int k = 0; k < space; k++) begin
            @(posedge pclk);
            rx <= '{valid: 1'b0, data: ~q[i]};
            frame_start <= 1'b0;
         end
      end
      @(posedge pclk);
      rx <= '{valid: 1'b0, data: ~q[q.size() - 1]};
      frame_start <= 1'b0;
   endtask : send
   // end of our transmission, reply expected
   task automatic sent();
      @(posedge pclk);
      tx_done <= 1'b1;
      @(posedge pclk);
      tx_done <= 1'b0;
   endtask : sent
endmodule : sfe_remote
`default_nettype wire

// [test/serial_frame_end_detector_test.sv]
// Purpose: self-checking bench for the frame end detector
// Assumes: MS_CYCLES of 10, baud divisor lowered to 4, then 1, for gap runs
// Notes: random bytes and lengths from a fixed seed
`include "sfe_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module serial_frame_end_detector_test;
   import sfe_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, frame_end, reply_err, in_frame;
   logic [6:0] end_cause;
   sfe_rx_t rx;
   logic frame_start, tx_done;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic er;
   logic [7:0] q[$];
   int n, v, w;
   localparam logic [7:0] DEF_A [7] = '{`SFE_OFF_SEL, `SFE_OFF_FIXED,
      `SFE_OFF_CAP, `SFE_OFF_REPLY, `SFE_OFF_WHOLE, `SFE_OFF_GAP,
      `SFE_OFF_BAUD};
   localparam logic [31:0] DEF_V [7] = '{32'h0, 32'h1, 32'h1, 32'hC8,
      32'hC8, 32'hC, 32'h364};
   always #5 pclk = ~pclk;
   sfe_frame_end #(.MS_CYCLES(10)) dut_u (.pclk(pclk), .presetn(presetn),
      .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx(rx), .frame_start(frame_start),
      .tx_done(tx_done), .frame_end(frame_end), .end_cause(end_cause),
      .reply_err(reply_err), .in_frame(in_frame));
   sfe_remote far_u (.pclk(pclk), .rx(rx), .frame_start(frame_start),
      .tx_done(tx_done));
   task automatic results();
      if (err_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t >= 50) begin
         err_count++;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // frame close seen once, inside a window of cycles
   task automatic wait_end(input logic [6:0] cause, input int lo,
      input int hi, input logic rerr);
      int t;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (frame_end !== 1'b1 && t < 300);
      check(32'(t >= lo && t <= hi), 32'h1);
      check({31'h0, reply_err}, {31'h0, rerr});
      check({25'h0, end_cause}, {25'h0, cause});
      @(posedge pclk);
      check({30'h0, frame_end, in_frame}, 32'h0);
   endtask : wait_end
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset
   function automatic int lf_end(int pos, int wid, int val, int m);
      return pos + wid - 1 + val + m;
   endfunction : lf_end
   initial begin
      void'($urandom(32'h9280));
      do_reset();
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, DEF_A[i], 32'h0);
         check(rd, DEF_V[i]);
      end
      apb(1'b0, 8'h3C, 32'h0);
      check({er, rd[30:0]}, 32'h8000_0000);
      // fixed length, random count
      n = 1 + $urandom % 8;
      apb(1'b1, `SFE_OFF_FIXED, 32'(n));
      apb(1'b1, `SFE_OFF_SEL, 32'h40);
      q = {};
      repeat (n + 2) q.push_back(8'($urandom));
      fork
         far_u.send(q, 0);
         wait_end(7'h40, n + 1, n + 4, 1'b0);
      join
      // cap and fixed firing together
      apb(1'b1, `SFE_OFF_FIXED, 32'h3);
      apb(1'b1, `SFE_OFF_CAP, 32'h3);
      apb(1'b1, `SFE_OFF_SEL, 32'h48);
      fork
         far_u.send(q, 0);
         wait_end(7'h48, 4, 7, 1'b0);
      join
      // status: byte count 3, both causes, idle
      apb(1'b0, `SFE_OFF_STATUS, 32'h0);
      check(rd, 32'h0003_4800);
      // two right-aligned delimiters, other places free
      apb(1'b1, `SFE_OFF_DMASK, 32'h18);
      apb(1'b1, `SFE_OFF_DPAT_LO, 32'h0D00_0000);
      apb(1'b1, `SFE_OFF_DPAT_HI, 32'h16);
      apb(1'b1, `SFE_OFF_SEL, 32'h20);
      q = {};
      n = 2 + $urandom % 5;
      repeat (n) q.push_back(8'h30 + 8'($urandom % 10));
      q.push_back(8'h0D);
      q.push_back(8'h16);
      fork
         far_u.send(q, 0);
         wait_end(7'h20, n + 3, n + 6, 1'b0);
      join
      // length field of every width
      apb(1'b1, `SFE_OFF_LFPOS, 32'h2);
      apb(1'b1, `SFE_OFF_TRAIL, 32'h1);
      apb(1'b1, `SFE_OFF_SEL, 32'h10);
      for (int k = 0; k < 3; k++) begin
         w = 1 << k;
         v = $urandom % 5;
         apb(1'b1, `SFE_OFF_LFW, 32'(w));
         q = {8'hA5};
         for (int b = w - 1; b >= 0; b--) q.push_back(8'(v >> (8 * b)));
         repeat (v + 4) q.push_back(8'($urandom));
         n = lf_end(2, w, v, 1);
         fork
            far_u.send(q, 0);
            wait_end(7'h10, n + 1, n + 4, 1'b0);
         join
      end
      // character gap in bit times
      apb(1'b1, `SFE_OFF_BAUD, 32'h4);
      apb(1'b1, `SFE_OFF_SEL, 32'h04);
      q = {8'h11, 8'h22, 8'h33};
      fork
         far_u.send(q, 2);
         wait_end(7'h04, 50, 75, 1'b0);
      join
      // fast line, gap limit at the advised floor
      apb(1'b1, `SFE_OFF_BAUD, 32'h1);
      apb(1'b1, `SFE_OFF_GAP, 32'h64);
      q = {8'h66, 8'h77};
      fork
         far_u.send(q, 2);
         wait_end(7'h04, 100, 115, 1'b0);
      join
      // whole frame timer
      apb(1'b1, `SFE_OFF_WHOLE, 32'h3);
      apb(1'b1, `SFE_OFF_SEL, 32'h02);
      q = {8'h44, 8'h55};
      fork
         far_u.send(q, 3);
         wait_end(7'h02, 20, 45, 1'b0);
      join
      // reply never comes
      apb(1'b1, `SFE_OFF_FIXED, 32'h1);
      apb(1'b1, `SFE_OFF_REPLY, 32'h2);
      apb(1'b1, `SFE_OFF_SEL, 32'h41);
      fork
         far_u.sent();
         wait_end(7'h01, 12, 35, 1'b1);
      join
      // write, read back, then power return
      v = 1 + $urandom % 4000;
      apb(1'b1, `SFE_OFF_CAP, 32'(v));
      apb(1'b0, `SFE_OFF_CAP, 32'h0);
      check(rd, 32'(v));
      do_reset();
      apb(1'b0, `SFE_OFF_CAP, 32'h0);
      check(rd, 32'h1);
      results();
   end
endmodule : serial_frame_end_detector_test
`default_nettype wire
